// >>> hdl/iju_jump_unit.sv
// interruptible jump unit: ijmpf, ijmpt and ijmpi resolution
// Notes on behaviour
// RULE_01: false-jump, idle, cond clear: load all counters
// RULE_02: false-jump, pending, cond clear: destination only, service
// RULE_03: exception served before interrupt
// RULE_04: false-jump with cond set: fall through
// RULE_05: false-jump guard clear: counters unchanged
// RULE_06: immediate jump, idle: load all counters
// RULE_07: immediate jump, pending: destination only, service
// RULE_08: immediate jump opcode 179, no operands
// RULE_09: branch unit, delay three, slots 2-4
// RULE_10: immediate jump guard clear: counters unchanged
// RULE_11: true-jump, idle, cond set: load all counters
// RULE_12: true-jump, pending, cond set: destination only, service
// RULE_13: true-jump with cond clear: fall through
// RULE_14: true-jump guard clear: counters unchanged
// RULE_15: destination counter kept for handler resume
`timescale 1ns/1ps
`include "iju_params.svh"
module iju_jump_unit
   import iju_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // issue side
   input wire logic issue_valid,
   input wire logic [7:0] issue_opcode,
   input wire logic [2:0] issue_slot,
   input wire logic guard_present,
   input wire logic [31:0] guard_operand,
   input wire logic [31:0] condition_operand,
   input wire logic [31:0] target_operand,
   input wire logic [31:0] issue_modifier,
   // exception and interrupt side
   input wire logic exception_pending,
   input wire logic interrupt_pending,
   // counters and service requests
   output logic [31:0] destination_counter,
   output logic [31:0] program_counter,
   output logic [31:0] saved_counter,
   output logic pc_load,
   output logic service_exception,
   output logic service_interrupt,
   output logic issue_illegal,
   output logic jump_busy
);
   function automatic logic is_jump(input logic [7:0] opc);
      return (opc == `IJU_OPC_IJMPI) || (opc == `IJU_OPC_IJMPF) ||
             (opc == `IJU_OPC_IJMPT);
   endfunction : is_jump

   logic jump_op;
   logic slot_ok;
   logic guard_ok;
   logic cond_ok;
   logic take;
   logic [31:0] target;
   logic d_valid;
   logic d_take;
   logic [1:0] d_svc;
   logic [31:0] d_target;
   logic [1:0] svc_now;
   iju_state_e state_r;
   logic [1:0] cnt_r;

   assign jump_op = issue_valid && is_jump(issue_opcode);
   assign slot_ok = (issue_slot >= `IJU_SLOT_MIN) && (issue_slot <= `IJU_SLOT_MAX); // RULE_09
   assign guard_ok = !guard_present || guard_operand[0]; // RULE_05 RULE_10 RULE_14

   always_comb begin
      cond_ok = 1'b0;
      target = target_operand;
      case (issue_opcode)
         `IJU_OPC_IJMPF: cond_ok = !condition_operand[0]; // RULE_01 RULE_04
         `IJU_OPC_IJMPT: cond_ok = condition_operand[0]; // RULE_11 RULE_13
         `IJU_OPC_IJMPI: begin
            cond_ok = 1'b1; // RULE_08
            target = issue_modifier; // RULE_06
         end
         default: cond_ok = 1'b0;
      endcase
   end

   assign take = jump_op && slot_ok && guard_ok && cond_ok;
   assign issue_illegal = jump_op && !slot_ok;

   // pending status sampled when the jump resolves; exception first
   always_comb begin
      if (exception_pending) begin
         svc_now = `IJU_SVC_EXC; // RULE_03
      end else if (interrupt_pending) begin
         svc_now = `IJU_SVC_INT;
      end else begin
         svc_now = `IJU_SVC_NONE;
      end
   end

   iju_delay_line u_delay (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .in_valid(jump_op && slot_ok),
      .in_take(take),
      .in_svc(svc_now),
      .in_target(target),
      .out_valid(d_valid),
      .out_take(d_take),
      .out_svc(d_svc),
      .out_target(d_target)
   );

   // destination counter
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         destination_counter <= `IJU_RESET_PC;
      end else if (d_valid && d_take) begin
         destination_counter <= d_target; // RULE_02 RULE_07 RULE_12 RULE_15
      end
   end

   // program and saved counters only when nothing is serviced
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         program_counter <= `IJU_RESET_PC;
         saved_counter <= `IJU_RESET_PC;
         pc_load <= 1'b0;
      end else begin
         pc_load <= d_valid && d_take && (d_svc == `IJU_SVC_NONE);
         if (d_valid && d_take && (d_svc == `IJU_SVC_NONE)) begin
            program_counter <= d_target; // RULE_01 RULE_06 RULE_11
            saved_counter <= d_target;
         end
      end
   end

   // service requests
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         service_exception <= 1'b0;
         service_interrupt <= 1'b0;
      end else begin
         service_exception <= d_valid && d_take && (d_svc == `IJU_SVC_EXC); // RULE_02 RULE_03
         service_interrupt <= d_valid && d_take && (d_svc == `IJU_SVC_INT); // RULE_07 RULE_12
      end
   end

   // delay tracker
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= IJU_IDLE;
         cnt_r <= 2'h0;
      end else begin
         case (state_r)
            IJU_IDLE: begin
               if (take) begin
                  state_r <= IJU_WAIT;
                  cnt_r <= `IJU_DELAY - 2'h1;
               end
            end
            IJU_WAIT: begin
               if (cnt_r == 2'h0) begin
                  state_r <= take ? IJU_WAIT : IJU_IDLE;
                  cnt_r <= `IJU_DELAY - 2'h1;
               end else begin
                  cnt_r <= cnt_r - 2'h1;
               end
            end
            default: state_r <= IJU_IDLE;
         endcase
      end
   end
   assign jump_busy = (state_r == IJU_WAIT);

   sequence s_take_idle;
      take && !exception_pending && !interrupt_pending;
   endsequence

   sequence s_all_loaded;
      pc_load && program_counter == $past(target, 4) &&
         saved_counter == $past(target, 4) && destination_counter == $past(target, 4);
   endsequence

   property p_all_load;
      @(posedge sys_clk) disable iff (!resetn)
      s_take_idle |-> ##4 s_all_loaded;
   endproperty
   a_all_load: assert property (p_all_load) else $error("counters not loaded"); // RULE_01

   property p_dest_only;
      @(posedge sys_clk) disable iff (!resetn)
      (take && (exception_pending || interrupt_pending)) |-> ##4 !pc_load &&
         (service_exception || service_interrupt) &&
         destination_counter == $past(target, 4);
   endproperty
   a_dest_only: assert property (p_dest_only) else $error("pending jump loaded pc"); // RULE_02

   property p_exc_first;
      @(posedge sys_clk) disable iff (!resetn)
      (take && exception_pending) |-> ##4 (service_exception && !service_interrupt);
   endproperty
   a_exc_first: assert property (p_exc_first) else $error("interrupt beat exception"); // RULE_03

   property p_f_fall;
      @(posedge sys_clk) disable iff (!resetn)
      (issue_valid && issue_opcode == `IJU_OPC_IJMPF && condition_operand[0]) |-> !take;
   endproperty
   a_f_fall: assert property (p_f_fall) else $error("false jump taken on set"); // RULE_04

   property p_guard;
      @(posedge sys_clk) disable iff (!resetn)
      (guard_present && !guard_operand[0]) |-> !take;
   endproperty
   a_guard: assert property (p_guard) else $error("guarded jump taken"); // RULE_05

   property p_imm_target;
      @(posedge sys_clk) disable iff (!resetn)
      (take && issue_opcode == `IJU_OPC_IJMPI) |-> ##3 (d_target == $past(issue_modifier, 3));
   endproperty
   a_imm_target: assert property (p_imm_target) else $error("wrong immediate target"); // RULE_06

   property p_slot;
      @(posedge sys_clk) disable iff (!resetn)
      (jump_op && (issue_slot < `IJU_SLOT_MIN || issue_slot > `IJU_SLOT_MAX)) |->
         (issue_illegal && !take);
   endproperty
   a_slot: assert property (p_slot) else $error("jump in bad slot"); // RULE_09

   property p_t_fall;
      @(posedge sys_clk) disable iff (!resetn)
      (issue_valid && issue_opcode == `IJU_OPC_IJMPT && !condition_operand[0]) |-> !take;
   endproperty
   a_t_fall: assert property (p_t_fall) else $error("true jump taken on clear"); // RULE_13

   property p_hold;
      @(posedge sys_clk) disable iff (!resetn)
      !d_take |=> $stable(destination_counter) && $stable(program_counter);
   endproperty
   a_hold: assert property (p_hold) else $error("counters moved without jump"); // RULE_15
endmodule : iju_jump_unit

// >>> hdl/iju_params.svh
// constants for the interruptible jump unit
`ifndef IJU_PARAMS_SVH
`define IJU_PARAMS_SVH
`define IJU_OPC_IJMPI 8'hb3
`define IJU_OPC_IJMPF 8'hb4
`define IJU_OPC_IJMPT 8'hb5
`define IJU_DELAY 2'h3
`define IJU_SLOT_MIN 3'h2
`define IJU_SLOT_MAX 3'h4
`define IJU_RESET_PC 32'h00000000
`define IJU_SVC_EXC 2'h1
`define IJU_SVC_INT 2'h2
`define IJU_SVC_NONE 2'h0
`endif

// >>> hdl/iju_pkg.sv
// types for the interruptible jump unit
package iju_pkg;
   typedef enum logic [1:0] {
      IJU_IDLE = 2'b00,
      IJU_WAIT = 2'b01
   } iju_state_e;
   typedef logic [31:0] iju_word_t;
endpackage : iju_pkg

// >>> hdl/iju_delay_line.sv
// delay line holding a resolved jump for the branch delay slots
`timescale 1ns/1ps
`include "iju_params.svh"
module iju_delay_line
   import iju_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // pipeline input
   input wire logic in_valid,
   input wire logic in_take,
   input wire logic [1:0] in_svc,
   input wire logic [31:0] in_target,
   // pipeline output
   output logic out_valid,
   output logic out_take,
   output logic [1:0] out_svc,
   output logic [31:0] out_target
);
   logic [2:0] v_r;
   logic [2:0] t_r;
   logic [1:0] s_r [3];
   logic [31:0] a_r [3];

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         v_r <= 3'h0;
         t_r <= 3'h0;
      end else begin
         v_r <= {v_r[1:0], in_valid};
         t_r <= {t_r[1:0], in_take};
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_stage
         if (gi == 0) begin : g_first
            always_ff @(posedge sys_clk or negedge resetn) begin
               if (!resetn) begin
                  s_r[gi] <= `IJU_SVC_NONE;
                  a_r[gi] <= `IJU_RESET_PC;
               end else begin
                  s_r[gi] <= in_svc;
                  a_r[gi] <= in_target;
               end
            end
         end else begin : g_next
            always_ff @(posedge sys_clk or negedge resetn) begin
               if (!resetn) begin
                  s_r[gi] <= `IJU_SVC_NONE;
                  a_r[gi] <= `IJU_RESET_PC;
               end else begin
                  s_r[gi] <= s_r[gi-1];
                  a_r[gi] <= a_r[gi-1];
               end
            end
         end
      end
   endgenerate

   assign out_valid = v_r[2];
   assign out_take = t_r[2];
   assign out_svc = s_r[2];
   assign out_target = a_r[2];
endmodule : iju_delay_line

// >>> verif/iju_pend_model.sv
// far-side model: exception and interrupt pending levels
`timescale 1ns/1ps
module iju_pend_model (
   // reset
   input wire logic resetn,
   // requests from the bench
   input wire logic req_exc,
   input wire logic req_int,
   // pending levels to the jump unit
   output logic exception_pending,
   output logic interrupt_pending
);
   // levels drop while the core is in reset
   assign exception_pending = resetn & req_exc;
   assign interrupt_pending = resetn & req_int;
endmodule : iju_pend_model

// >>> verif/interruptible_jump_unit_tb.sv
// self-checking bench for the interruptible jump unit
`timescale 1ns/1ps
`include "iju_params.svh"
module interruptible_jump_unit_tb;
   import iju_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic issue_valid = 1'b0;
   logic guard_present = 1'b0;
   logic req_exc = 1'b0;
   logic req_int = 1'b0;
   logic [7:0] issue_opcode = 8'h00;
   logic [2:0] issue_slot = 3'h2;
   iju_word_t guard_operand = 32'h0, condition_operand = 32'h0;
   iju_word_t target_operand = 32'h0, issue_modifier = 32'h0;
   logic exception_pending, interrupt_pending, pc_load, service_exception;
   logic service_interrupt, issue_illegal, jump_busy;
   iju_word_t destination_counter, program_counter, saved_counter;
   int unsigned exp_dest = 0, exp_pc = 0, exp_saved = 0;
   int unsigned exp_q[$];
   int n_fail = 0, checks = 0;
   logic [31:0] seed = 32'h2e44;
   logic [7:0] opc_tab [5] = '{8'hb3, 8'hb4, 8'hb5, 8'hb3, 8'ha0};
   always #25 sys_clk = ~sys_clk;
   iju_pend_model iju_pend_model_inst (.resetn(resetn), .req_exc(req_exc), .req_int(req_int),
      .exception_pending(exception_pending), .interrupt_pending(interrupt_pending));
   iju_jump_unit iju_jump_unit_inst (.sys_clk(sys_clk), .resetn(resetn),
      .issue_valid(issue_valid), .issue_opcode(issue_opcode), .issue_slot(issue_slot),
      .guard_present(guard_present), .guard_operand(guard_operand),
      .condition_operand(condition_operand), .target_operand(target_operand),
      .issue_modifier(issue_modifier), .exception_pending(exception_pending),
      .interrupt_pending(interrupt_pending), .destination_counter(destination_counter),
      .program_counter(program_counter), .saved_counter(saved_counter), .pc_load(pc_load),
      .service_exception(service_exception), .service_interrupt(service_interrupt),
      .issue_illegal(issue_illegal), .jump_busy(jump_busy));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict
   task automatic op(input logic [7:0] opc, input logic [2:0] slot, input logic gp,
      input logic g, input logic [31:0] c, input logic [31:0] t, input logic e, input logic i);
      int np, ne, ni, w;
      logic isjmp, bad, take;
      np = 0;
      ne = 0;
      ni = 0;
      w = 0;
      while (jump_busy !== 1'b0 && w < 20) begin
         @(posedge sys_clk);
         w++;
      end
      if (jump_busy !== 1'b0) begin
         n_fail++;
         print_verdict();
      end
      isjmp = opc inside {8'hb3, 8'hb4, 8'hb5};
      bad = isjmp && !(slot inside {[3'h2:3'h4]});
      take = isjmp && !bad && (!gp || g)
         && (opc == 8'hb3 || (opc == 8'hb4 && !c[0]) || (opc == 8'hb5 && c[0]));
      @(posedge sys_clk);
      issue_valid <= 1'b1;
      issue_opcode <= opc;
      issue_slot <= slot;
      guard_present <= gp;
      guard_operand <= {31'h0, g};
      condition_operand <= c;
      target_operand <= (opc == 8'hb3) ? ~t : t;
      issue_modifier <= (opc == 8'hb3) ? t : ~t;
      req_exc <= e;
      req_int <= i;
      #1;
      chk(32'(issue_illegal), 32'(bad));
      @(posedge sys_clk);
      issue_valid <= 1'b0;
      req_exc <= 1'b0;
      req_int <= 1'b0;
      for (int k = 0; k < 8; k++) begin
         @(posedge sys_clk);
         #1;
         if (k == 0) begin
            chk(32'(jump_busy), 32'(take));
         end
         np += int'(pc_load === 1'b1);
         ne += int'(service_exception === 1'b1);
         ni += int'(service_interrupt === 1'b1);
      end
      if (take) begin
         exp_dest = t;
         if (!e && !i) begin
            exp_pc = t;
            exp_saved = t;
         end
      end
      exp_q.push_back(exp_dest);
      exp_q.push_back(exp_pc);
      exp_q.push_back(exp_saved);
      chk(destination_counter, exp_q.pop_front());
      chk(program_counter, exp_q.pop_front());
      chk(saved_counter, exp_q.pop_front());
      chk(32'(np), 32'(take && !e && !i));
      chk(32'(ne), 32'(take && e));
      chk(32'(ni), 32'(take && !e && i));
      chk(32'(jump_busy), 32'h0);
   endtask : op
   initial begin
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      chk(program_counter, `IJU_RESET_PC);
      op(`IJU_OPC_IJMPI, 3'h2, 1'b0, 1'b0, 32'h0, 32'h330, 1'b0, 1'b0);
      op(`IJU_OPC_IJMPF, 3'h3, 1'b1, 1'b1, 32'h0, 32'h8000, 1'b1, 1'b1);
      op(`IJU_OPC_IJMPT, 3'h4, 1'b0, 1'b0, 32'h1, 32'h440, 1'b0, 1'b1);
      op(`IJU_OPC_IJMPI, 3'h4, 1'b0, 1'b0, 32'h0, 32'h550, 1'b1, 1'b0);
      op(`IJU_OPC_IJMPI, 3'h3, 1'b1, 1'b0, 32'h0, 32'h8000, 1'b0, 1'b0);
      op(`IJU_OPC_IJMPF, 3'h2, 1'b0, 1'b0, 32'h1, 32'h660, 1'b0, 1'b0);
      op(`IJU_OPC_IJMPT, 3'h2, 1'b0, 1'b0, 32'h2, 32'h770, 1'b0, 1'b0);
      op(`IJU_OPC_IJMPF, 3'h3, 1'b1, 1'b0, 32'h0, 32'h880, 1'b0, 1'b0);
      op(`IJU_OPC_IJMPT, 3'h4, 1'b1, 1'b0, 32'h1, 32'h990, 1'b0, 1'b0);
      op(`IJU_OPC_IJMPI, 3'h5, 1'b0, 1'b0, 32'h0, 32'haa0, 1'b0, 1'b0);
      op(`IJU_OPC_IJMPT, 3'h3, 1'b1, 1'b1, 32'h1, 32'h9a0, 1'b0, 1'b0);
      op(`IJU_OPC_IJMPF, 3'h2, 1'b0, 1'b0, 32'h0, 32'hbb0, 1'b0, 1'b0);
      $display("directed jumps done");
      for (int n = 0; n < 60; n++) begin
         seed = xs(seed);
         op(opc_tab[seed[2:0] % 5], 3'(seed[6:4] % 5 + 1), seed[7], seed[8], xs(seed),
            xs(~seed), seed[9], seed[10]);
      end
      $display("random jumps done");
      print_verdict();
   end
endmodule : interruptible_jump_unit_tb
